// file: rtl/sts_pkg.sv
// Purpose: Constants for the state trigger sequencer.
// Assumes: One 10 MHz core clock; a sample is one state of the target.
// Notes: Every figure the sequencer depends on lives here, except the label count NLBL and the two-entry prestore depth.
// Notes on behaviour
// RQ1: Arm from run, external input, or other machine
// RQ2: Branches off removes all secondary branches
// RQ3: Restart mode: primary miss plus restart match returns
// RQ4: Per-level mode: secondary condition jumps to target
// RQ5: Storage macro level gets no extra secondary
// RQ6: Last level stores, may still branch
// RQ7: Branch targets stay on their side of trigger
// RQ8: One target per level, many sources allowed
// RQ9: Tagging halves depth to 512, rate 16.67 MHz
// RQ10: Time tag spans consecutive stored states, 48 hours
// RQ11: State tag counts qualified states, to 4.4e12
// RQ12: Tagging off collects no counts
// RQ13: Two-deep prestore keeps newest two matches
// RQ14: Prestore entries written just before stored state
// RQ15: Recognizers in groups a-d, e-h, one group each
// RQ16: One range recognizer, one label, 32 channels
// RQ17: Range goes to first label within two pods
// RQ18: Pattern match stores or triggers by level
// RQ19: Two to eight levels, trigger in first seven
// RQ20: Occurrence counter one to 65535 per level
// RQ21: Storage loop: enable, store, disable, repeat
// RQ22: One evaluation per sample, primary wins
package sts_pkg;
	localparam int          NLVL          = 8;
	localparam int          MIN_LVL       = 2;
	localparam int          LVL_W         = 3;
	localparam int          OCC_W         = 16;
	localparam int          DATA_W        = 32;
	localparam int          NPAT          = 8;
	localparam int          NPOD          = 4;
	localparam int          POD_W         = 8;
	localparam int          MAX_RNG_PODS  = 2;
	// Qualifier word layout
	localparam int          Q_W           = 8;
	localparam int          Q_ANY         = 7;
	localparam int          Q_GRP         = 6;
	localparam int          Q_PAT         = 2;
	localparam int          Q_RNG         = 0;
	localparam logic [1:0]  RNG_IN        = 2'h1;
	localparam logic [1:0]  RNG_OUT       = 2'h2;
	// Mode encodings
	localparam logic [1:0]  ARM_RUN       = 2'h0;
	localparam logic [1:0]  ARM_EXT       = 2'h1;
	localparam logic [1:0]  ARM_OTHER     = 2'h2;
	localparam logic [1:0]  BR_OFF        = 2'h0;
	localparam logic [1:0]  BR_RESTART    = 2'h1;
	localparam logic [1:0]  BR_PERLVL     = 2'h2;
	localparam logic [1:0]  CNT_OFF       = 2'h0;
	localparam logic [1:0]  CNT_TIME      = 2'h1;
	localparam logic [1:0]  CNT_STATES    = 2'h2;
	// Acquisition depth
	localparam int          DEPTH_W       = 11;
	localparam logic [10:0] DEPTH_FULL    = 11'h400;
	localparam logic [10:0] DEPTH_TAG     = 11'h200;
	localparam int          MAX_RATE_KHZ  = 16670;
	// Tag range
	localparam longint      CLK_HZ        = 10_000_000;
	localparam longint      TIME_MAX_HRS  = 48;
	localparam int          TAG_W         = 43;
	localparam logic [42:0] TIME_MAX_CYC  = 43'(TIME_MAX_HRS * 3600 * CLK_HZ);
	localparam logic [42:0] STATE_MAX     = 43'h400_746f_e000;
	localparam int          FIFO_DEPTH    = 8;
	localparam int          ENTRY_W       = DATA_W + TAG_W + 2;
	typedef enum logic [1:0] {STS_IDLE, STS_WAIT_ARM, STS_ACQ, STS_DONE} sts_run_e;
endpackage

// file: rtl/sts_fifo.sv
// Purpose: Small FIFO on the stored-state stream.
// Assumes: Same clock as the sequencer.
// Notes: Full and empty are exact; write refused while full.
`timescale 1ns/1ps
`default_nettype none
module sts_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic         core_clk_i,
	input  wire logic         srst_i,
	input  wire logic         ce_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	logic         push;
	logic         pop;

	////////////////////////////////////////////////////////////////
	// Handshake terms
	assign push        = in_valid_i & in_ready_o & ce_i;
	assign pop         = out_valid_o & out_ready_i & ce_i;
	assign in_ready_o  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
	assign out_valid_o = wr_ptr != rd_ptr;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];

	// Storage array
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	// Pointers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/sts_sequencer.sv
// Purpose: State trigger sequencer with tagging, prestore and range.
// Assumes: Samples come from logic on core_clk_i; external arm is a pin.
// Notes: Stored entries leave through an 8-word FIFO; time tags in 100 ns.
`timescale 1ns/1ps
`default_nettype none
module sts_sequencer #(
	parameter int NLBL = 4
) (
	input  wire logic                                    core_clk_i,
	input  wire logic                                    srst_i,
	input  wire logic                                    ce_i,
	input  wire logic                                    run_i,
	input  wire logic [1:0]                              arm_source_select_i,
	input  wire logic                                    external_arm_input_i,
	input  wire logic                                    other_arm_i,
	input  wire logic                                    other_off_i,
	input  wire logic                                    other_arm_source_select_us_i,
	input  wire logic [3:0]                              num_levels_i,
	input  wire logic [2:0]                              trig_level_i,
	input  wire logic                                    macro_en_i,
	input  wire logic [1:0]                              branch_mode_i,
	input  wire logic [1:0]                              count_mode_i,
	input  wire logic [sts_pkg::Q_W-1:0]                 restart_q_i,
	input  wire logic [sts_pkg::Q_W-1:0]                 count_q_i,
	input  wire logic [sts_pkg::NLVL*sts_pkg::Q_W-1:0]   lvl_store_q_i,
	input  wire logic [sts_pkg::NLVL*sts_pkg::Q_W-1:0]   lvl_prim_q_i,
	input  wire logic [sts_pkg::NLVL*sts_pkg::Q_W-1:0]   lvl_sec_q_i,
	input  wire logic [sts_pkg::NLVL*sts_pkg::Q_W-1:0]   lvl_pre_q_i,
	input  wire logic [sts_pkg::NLVL-1:0]                lvl_sec_en_i,
	input  wire logic [sts_pkg::NLVL-1:0]                lvl_pre_en_i,
	input  wire logic [sts_pkg::NLVL*sts_pkg::OCC_W-1:0] lvl_occ_i,
	input  wire logic [sts_pkg::NLVL*sts_pkg::LVL_W-1:0] lvl_sec_tgt_i,
	input  wire logic [sts_pkg::NPAT*sts_pkg::DATA_W-1:0] pat_val_i,
	input  wire logic [sts_pkg::NPAT*sts_pkg::DATA_W-1:0] pat_mask_i,
	input  wire logic [NLBL*sts_pkg::DATA_W-1:0]         label_chan_i,
	input  wire logic [sts_pkg::DATA_W-1:0]              range_lo_i,
	input  wire logic [sts_pkg::DATA_W-1:0]              range_hi_i,
	input  wire logic                                    sample_valid_i,
	input  wire logic [sts_pkg::DATA_W-1:0]              sample_data_i,
	output logic                                         sample_ready_o,
	output logic                                         st_valid_o,
	input  wire logic                                    st_ready_i,
	output logic [sts_pkg::ENTRY_W-1:0]                  st_entry_o,
	output logic [2:0]                                   level_o,
	output logic                                         armed_o,
	output logic                                         trig_o,
	output logic                                         full_o,
	output logic                                         range_avail_o
);
	localparam int EW = sts_pkg::ENTRY_W;
	localparam int TW = sts_pkg::TAG_W;
	sts_pkg::sts_run_e             run_st;
	logic [2:0]                    ext_sync;
	logic [2:0]                    lvl;
	logic [2:0]                    last;
	logic [sts_pkg::OCC_W-1:0]     occ;
	logic                          mac_ph;
	logic                          trig_done;
	logic [sts_pkg::DEPTH_W-1:0]   n_stored;
	logic [sts_pkg::TAG_W-1:0]     tag_ctr;
	logic [sts_pkg::DATA_W-1:0]    pre_old, pre_new;
	logic [1:0]                    pre_n;
	logic [EW-1:0]                 em [3];
	logic [1:0]                    em_n;
	logic [sts_pkg::NPAT-1:0]      pm;
	logic [sts_pkg::DATA_W-1:0]    rng_val;
	logic                          rng_ok, rin;
	logic [$clog2(NLBL+1)-1:0]     rng_lbl;
	logic                          step, is_mac, prim, sec_hit, rst_hit, st_hit, pre_hit, trig_now;
	logic [2:0]                    next_lvl, sec_tgt, tgt_q;
	logic                          tgt_ok, occ_done, fifo_rdy, tag_on;
	logic [sts_pkg::DEPTH_W-1:0]   depth_lim;

	// Qualifier: one recognizer group plus the range term
	function automatic logic qual(input logic [7:0] q, input logic [7:0] p, input logic r,
		input logic ok);
		logic [3:0] g;
		g = q[sts_pkg::Q_GRP] ? p[7:4] : p[3:0]; // RQ15
		return q[sts_pkg::Q_ANY] | (|(q[sts_pkg::Q_PAT+:4] & g))
			| (ok & (q[sts_pkg::Q_RNG+:2] == sts_pkg::RNG_IN) & r)
			| (ok & (q[sts_pkg::Q_RNG+:2] == sts_pkg::RNG_OUT) & !r);
	endfunction

	////////////////////////////////////////////////////////////////
	// Pattern recognizers
	for (genvar i = 0; i < sts_pkg::NPAT; i++) begin : g_pat
		assign pm[i] = ((sample_data_i ^ pat_val_i[i*32+:32]) & pat_mask_i[i*32+:32]) == '0;
	end

	// Range label choice: first label within two pods
	always_comb begin
		int pods;
		pods    = 0;
		rng_ok  = 1'b0;
		rng_lbl = '0;
		for (int l = NLBL - 1; l >= 0; l--) begin
			pods = 0;
			for (int p = 0; p < sts_pkg::NPOD; p++) begin
				pods = pods + int'(|label_chan_i[l*32+p*8+:8]);
			end
			if (pods <= sts_pkg::MAX_RNG_PODS && pods > 0) begin
				rng_ok  = 1'b1; // RQ17
				rng_lbl = l[$clog2(NLBL+1)-1:0];
			end
		end
	end

	// Range value gathered from non-adjacent channels of the label
	always_comb begin
		int j;
		logic [31:0] m;
		j       = 0;
		m       = label_chan_i[rng_lbl*32+:32];
		rng_val = '0;
		for (int b = 0; b < sts_pkg::DATA_W; b++) begin
			if (m[b]) begin
				rng_val[j[4:0]] = sample_data_i[b]; // RQ16
				j = j + 1;
			end
		end
		rin = (rng_val >= range_lo_i) && (rng_val <= range_hi_i);
	end

	////////////////////////////////////////////////////////////////
	// Level decode
	assign last      = (num_levels_i < 4'(sts_pkg::MIN_LVL)) ? 3'h1 :
		(num_levels_i > 4'(sts_pkg::NLVL)) ? 3'h7 : 3'(num_levels_i - 4'h1); // RQ19
	assign is_mac    = macro_en_i && (lvl == last - 3'h1);
	assign tag_on    = count_mode_i != sts_pkg::CNT_OFF;
	assign depth_lim = tag_on ? sts_pkg::DEPTH_TAG : sts_pkg::DEPTH_FULL; // RQ9
	assign step      = sample_valid_i & sample_ready_o & (run_st == sts_pkg::STS_ACQ) & ce_i;

	// Current-level condition evaluation
	always_comb begin
		logic [2:0] cl;
		logic [sts_pkg::OCC_W-1:0] lim;
		cl      = (is_mac && mac_ph) ? last : lvl;
		lim     = lvl_occ_i[cl*16+:16];
		prim    = (lvl != last || is_mac) && qual(lvl_prim_q_i[cl*8+:8], pm, rin, rng_ok);
		occ_done = prim && (occ + 16'h1 >= lim); // RQ20
		st_hit  = qual(lvl_store_q_i[cl*8+:8], pm, rin, rng_ok);
		pre_hit = lvl_pre_en_i[lvl] && qual(lvl_pre_q_i[lvl*8+:8], pm, rin, rng_ok);
		rst_hit = (branch_mode_i == sts_pkg::BR_RESTART) &&
			qual(restart_q_i, pm, rin, rng_ok); // RQ3
		sec_tgt = lvl_sec_tgt_i[lvl*3+:3]; // RQ8
		tgt_ok  = (lvl <= trig_level_i) ? (sec_tgt <= trig_level_i) :
			(sec_tgt > trig_level_i && sec_tgt <= last); // RQ7
		sec_hit = (branch_mode_i == sts_pkg::BR_PERLVL) && !is_mac && lvl_sec_en_i[lvl] &&
			tgt_ok && qual(lvl_sec_q_i[lvl*8+:8], pm, rin, rng_ok); // RQ4 RQ5 RQ6
	end

	// Next level: primary wins over secondary and restart
	always_comb begin
		next_lvl = lvl;
		trig_now = 1'b0;
		tgt_q    = sec_tgt;
		if (is_mac) begin
			next_lvl = lvl; // RQ21
		end else if (occ_done) begin
			next_lvl = lvl + 3'h1; // RQ22
			trig_now = (lvl == trig_level_i) && !trig_done; // RQ18
		end else if (!prim && rst_hit) begin
			next_lvl = 3'h0; // RQ3
		end else if (!prim && sec_hit) begin
			next_lvl = tgt_q; // RQ4
		end
		if (branch_mode_i == sts_pkg::BR_OFF && !occ_done) begin
			next_lvl = lvl; // RQ2
		end
	end

	////////////////////////////////////////////////////////////////
	// External arm synchroniser and edge
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ext_sync <= '0;
		end else if (ce_i) begin
			ext_sync <= {ext_sync[1:0], external_arm_input_i};
		end
	end

	// Run and arm control
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			run_st <= sts_pkg::STS_IDLE;
		end else if (ce_i) begin
			case (run_st)
				sts_pkg::STS_IDLE, sts_pkg::STS_DONE: begin
					if (run_i) begin
						run_st <= sts_pkg::STS_WAIT_ARM;
					end
				end
				sts_pkg::STS_WAIT_ARM: begin
					case (arm_source_select_i)
						sts_pkg::ARM_EXT: begin
							if (ext_sync[1] && !ext_sync[2]) begin
								run_st <= sts_pkg::STS_ACQ; // RQ1
							end
						end
						sts_pkg::ARM_OTHER: begin
							if (other_off_i || other_arm_source_select_us_i || other_arm_i) begin
								run_st <= sts_pkg::STS_ACQ; // RQ1
							end
						end
						default: begin
							run_st <= sts_pkg::STS_ACQ;
						end
					endcase
				end
				sts_pkg::STS_ACQ: begin
					if (run_i) begin
						run_st <= sts_pkg::STS_WAIT_ARM;
					end else if (n_stored >= depth_lim) begin
						run_st <= sts_pkg::STS_DONE;
					end
				end
				default: begin
					run_st <= sts_pkg::STS_IDLE;
				end
			endcase
		end
	end

	// Sequencer level, occurrences and storage loop phase
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			lvl       <= '0;
			occ       <= '0;
			mac_ph    <= 1'b0;
			trig_done <= 1'b0;
		end else if (ce_i) begin
			if (run_i) begin
				lvl       <= '0;
				occ       <= '0;
				mac_ph    <= 1'b0;
				trig_done <= 1'b0;
			end else if (step) begin
				lvl <= next_lvl;
				if (trig_now) begin
					trig_done <= 1'b1;
				end
				if (occ_done || next_lvl != lvl) begin
					occ <= '0;
				end else if (prim) begin
					occ <= occ + 16'h1;
				end
				if (is_mac && occ_done) begin
					mac_ph <= !mac_ph; // RQ21
				end
			end
		end
	end

	// Tag counter between stored states
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tag_ctr <= '0;
		end else if (ce_i) begin
			if (!tag_on || run_i) begin
				tag_ctr <= '0; // RQ12
			end else if (step && (st_hit || trig_now)) begin
				tag_ctr <= (count_mode_i == sts_pkg::CNT_STATES) ? '0 : TW'(1);
			end else if (count_mode_i == sts_pkg::CNT_TIME && run_st == sts_pkg::STS_ACQ) begin
				if (tag_ctr < sts_pkg::TIME_MAX_CYC) begin
					tag_ctr <= tag_ctr + TW'(1); // RQ10
				end
			end else if (step && qual(count_q_i, pm, rin, rng_ok)) begin
				if (tag_ctr < sts_pkg::STATE_MAX) begin
					tag_ctr <= tag_ctr + TW'(1); // RQ11
				end
			end
		end
	end

	// Prestore history and emission queue
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pre_n   <= '0;
			pre_old <= '0;
			pre_new <= '0;
			em_n    <= '0;
			em[0]   <= '0;
			em[1]   <= '0;
			em[2]   <= '0;
			sample_ready_o <= 1'b0;
		end else if (ce_i) begin
			if (step && (st_hit || trig_now)) begin
				em[0] <= (pre_n == 2'h2) ? {2'b10, TW'(0), pre_old} : // RQ14
					(pre_n == 2'h1) ? {2'b10, TW'(0), pre_new} :
					{1'b0, trig_now, tag_ctr, sample_data_i};
				em[1] <= (pre_n == 2'h2) ? {2'b10, TW'(0), pre_new} :
					{1'b0, trig_now, tag_ctr, sample_data_i};
				em[2] <= {1'b0, trig_now, tag_ctr, sample_data_i};
				em_n  <= pre_n + 2'h1;
				pre_n <= '0;
				sample_ready_o <= 1'b0;
			end else begin
				if (step && pre_hit) begin
					pre_old <= pre_new; // RQ13
					pre_new <= sample_data_i;
					pre_n   <= (pre_n == 2'h2) ? 2'h2 : pre_n + 2'h1;
				end
				if (em_n != 2'h0 && fifo_rdy) begin
					em[0] <= em[1];
					em[1] <= em[2];
					em_n  <= em_n - 2'h1;
				end
				sample_ready_o <= (run_st == sts_pkg::STS_ACQ) &&
					(em_n == 2'h0 || (em_n == 2'h1 && fifo_rdy));
			end
		end
	end

	// Stored entry count against the active depth
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			n_stored <= '0;
		end else if (ce_i) begin
			if (run_i) begin
				n_stored <= '0;
			end else if (em_n != 2'h0 && fifo_rdy && n_stored < depth_lim) begin
				n_stored <= n_stored + 11'h1; // RQ9
			end
		end
	end

	// Status outputs
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			level_o       <= '0;
			armed_o       <= 1'b0;
			trig_o        <= 1'b0;
			full_o        <= 1'b0;
			range_avail_o <= 1'b0;
		end else if (ce_i) begin
			level_o       <= lvl;
			armed_o       <= run_st == sts_pkg::STS_ACQ;
			trig_o        <= step && trig_now;
			full_o        <= n_stored >= depth_lim;
			range_avail_o <= rng_ok;
		end
	end

	// Output buffer on the stored-state stream
	sts_fifo #(
		.W     (EW),
		.DEPTH (sts_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.srst_i      (srst_i),
		.ce_i        (ce_i),
		.in_valid_i  (em_n != 2'h0 && n_stored < depth_lim),
		.in_ready_o  (fifo_rdy),
		.in_data_i   (em[0]),
		.out_valid_o (st_valid_o),
		.out_ready_i (st_ready_i),
		.out_data_o  (st_entry_o)
	);

	////////////////////////////////////////////////////////////////
	// Checks
	sequence s_store_step;
		step && (st_hit || trig_now);
	endsequence
	sequence s_trig_step;
		step && trig_now;
	endsequence

	a_trig_pulse: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ18
		s_trig_step ##1 1'b1 |-> trig_o && $past(lvl) == trig_level_i)
		else $error("trigger pulse missing");
	a_restart_first: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ3
		step && !prim && rst_hit && !is_mac && branch_mode_i == sts_pkg::BR_RESTART
		|=> lvl == 3'h0) else $error("restart did not return to first level");
	a_primary_wins: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ22
		step && !run_i && occ_done && !is_mac |=> lvl == $past(lvl) + 3'h1)
		else $error("primary did not advance");
	a_branch_side: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ7
		step && !occ_done && !rst_hit && lvl <= trig_level_i |=> lvl <= trig_level_i)
		else $error("branch crossed the trigger level");
	a_branch_off: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ2
		step && !run_i && !occ_done && branch_mode_i == sts_pkg::BR_OFF |=> $stable(lvl))
		else $error("secondary branch taken while off");
	a_depth_limit: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ9
		tag_on |-> n_stored <= sts_pkg::DEPTH_TAG || $past(!tag_on))
		else $error("tagged depth exceeded");
	a_tag_off_zero: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ12
		ce_i && !tag_on |=> tag_ctr == '0) else $error("count kept while off");
	a_prestore_ahead: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ14
		s_store_step and (pre_n == 2'h2 && ce_i) |=> em_n == 2'h3 && em[0][EW-1])
		else $error("prestore entries not queued first");
	a_prestore_cap: assert property (@(posedge core_clk_i) disable iff (srst_i) // RQ13
		pre_n <= 2'h2) else $error("prestore holds more than two");
endmodule
`default_nettype wire

// file: tb/sts_target_model.sv
// Purpose: Target system model that feeds sampled states.
// Assumes: Requests change 1 ns after the clock edge.
// Notes: An idle data line shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module sts_target_model (
	input  wire logic   core_clk_i,
	input  wire logic   ready_i,
	output logic        valid_o,
	output logic [31:0] data_o
);
	logic [31:0] q[$];
	logic        slow = 1'b0;
	initial begin
		valid_o = 1'b0;
		data_o  = 32'h0;
	end
	////////////////////////////////////////
	// Hold each state until taken, then next or idle
	always @(posedge core_clk_i) begin
		if (valid_o && ready_i) begin
			#1;
			if (q.size() != 0 && !slow) begin
				data_o = q.pop_front();
			end else begin
				valid_o = 1'b0;
				data_o  = ~data_o;
			end
		end else if (!valid_o && q.size() != 0) begin
			#1;
			valid_o = 1'b1;
			data_o  = q.pop_front();
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_sts_sequencer.sv
// Purpose: Self-checking bench for the state trigger sequencer.
// Assumes: Samples come from the target model; stream drained here.
// Notes: Rows walk the restart case and mrow the storage loop; the rest are hand-written.
`timescale 1ns/1ps
`default_nettype none
module tb_sts_sequencer;
	localparam int EW = sts_pkg::ENTRY_W;
	typedef struct packed {logic [31:0] d; logic [2:0] l;} sts_row_s;
	localparam logic [31:0] PA = 32'h0, PB = 32'h11111111, PC = 32'h22222222;
	localparam logic [31:0] PE = 32'h44444444, PX = 32'h99999999;
	logic core_clk_i = 1'b0, srst_i = 1'b1, ce = 1'b1, run = 1'b0, ext = 1'b0;
	logic oth = 1'b0, off = 1'b0, by = 1'b0, mac = 1'b0, st_rdy = 1'b1;
	logic [1:0] asel = 2'h0, br = 2'h0, cnt = 2'h0;
	logic [3:0] nlv = 4'h2;
	logic [2:0] trg = 3'h0, lvl;
	logic [7:0] rq = 8'h0, cq = 8'h0, sen = 8'h0, pen = 8'h0;
	logic [63:0] stq = '0, prq = '0, scq = '0, peq = '0;
	logic [127:0] occ = '0, lbl = '1;
	logic [23:0] tgt = '0;
	logic [31:0] rlo = '0, rhi = '1, s_dat;
	logic [255:0] pv, pm;
	logic s_vld, s_rdy, st_vld, armed, trig, full, ravl;
	logic [EW-1:0] ent;
	logic [EW-1:0] got[$];
	int bad_count = 0, total_checks = 0, trigs = 0;
	sts_row_s rows[11] = '{'{PA, 3'h0}, '{PA, 3'h0}, '{PX, 3'h0}, '{PA, 3'h1}, '{PB, 3'h0},
		'{PA, 3'h0}, '{PA, 3'h0}, '{PA, 3'h1}, '{PX, 3'h1}, '{PC, 3'h2}, '{PX, 3'h2}};
	logic [31:0] mrow[7] = '{PA, PE, PX, PB, PX, PC, PX};
	////////////////////////////////////////
	sts_target_model u_sts_target_model (.core_clk_i(core_clk_i), .ready_i(s_rdy),
		.valid_o(s_vld), .data_o(s_dat));
	sts_sequencer u_sts_sequencer (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce),
		.run_i(run), .arm_source_select_i(asel), .external_arm_input_i(ext),
		.other_arm_i(oth), .other_off_i(off), .other_arm_source_select_us_i(by),
		.num_levels_i(nlv), .trig_level_i(trg), .macro_en_i(mac), .branch_mode_i(br),
		.count_mode_i(cnt), .restart_q_i(rq), .count_q_i(cq), .lvl_store_q_i(stq),
		.lvl_prim_q_i(prq), .lvl_sec_q_i(scq), .lvl_pre_q_i(peq), .lvl_sec_en_i(sen),
		.lvl_pre_en_i(pen), .lvl_occ_i(occ), .lvl_sec_tgt_i(tgt), .pat_val_i(pv),
		.pat_mask_i(pm), .label_chan_i(lbl), .range_lo_i(rlo), .range_hi_i(rhi),
		.sample_valid_i(s_vld), .sample_data_i(s_dat), .sample_ready_o(s_rdy),
		.st_valid_o(st_vld), .st_ready_i(st_rdy), .st_entry_o(ent), .level_o(lvl),
		.armed_o(armed), .trig_o(trig), .full_o(full), .range_avail_o(ravl));
	////////////////////////////////////////
	// Clock, stream collector and trigger counter
	always #50 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		if (st_vld && st_rdy) got.push_back(ent);
		if (trig) trigs++;
	end
	////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic drain();
		for (int i = 0; i < 3000 && (u_sts_target_model.q.size() != 0 || s_vld); i++) cyc(1);
		cyc(6);
	endtask
	task automatic send(input logic [31:0] d);
		u_sts_target_model.q.push_back(d);
		drain();
	endtask
	task automatic pulse();
		run = 1'b1;
		cyc(1);
		run = 1'b0;
		cyc(6);
	endtask
	task automatic chk_val(input logic [41:0] g, input logic [41:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask
	task automatic chk_lvl(input logic [2:0] e);
		total_checks++;
		if (lvl !== e) begin
			bad_count++;
			$display("Error at %0t: level %0d expected %0d", $time, lvl, e);
		end
	endtask
	task automatic stop_test();
		$display("Checks %0d, errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// Watchdog
	initial begin
		#2000000;
		bad_count++;
		stop_test();
	end
	////////////////////////////////////////
	// Main sequence
	initial begin
		for (int i = 0; i < 8; i++) begin
			pv[i*32+:32] = {8{i[3:0]}};
			pm[i*32+:32] = 32'hffffffff;
		end
		pm[96+:32] = 32'hf;
		cyc(20);
		chk_val(42'({lvl, armed, trig, full}), 42'h0);
		srst_i = 1'b0;
		cyc(3);
		chk_val(42'(ravl), 42'h0);
		lbl[64+:32] = 32'h00ff00ff;
		cyc(3);
		chk_val(42'(ravl), 42'h1);
		// Restart walk, occurrence count of three
		nlv = 4'h3;
		trg = 3'h1;
		br = sts_pkg::BR_RESTART;
		rq = 8'h08;
		prq[15:0] = 16'h1004;
		occ[31:0] = 32'h00010003;
		pulse();
		foreach (rows[i]) begin
			send(rows[i].d);
			chk_lvl(rows[i].l);
		end
		chk_val(42'(trigs), 42'h1);
		chk_val(42'(got.size()), 42'h1);
		chk_val(42'(got[0][EW-2]), 42'h1);
		// Per-level branch, primary precedence, branches off
		nlv = 4'h4;
		trg = 3'h2;
		br = sts_pkg::BR_PERLVL;
		prq[23:0] = 24'h201004;
		occ[47:0] = 48'h000100010001;
		scq[15:0] = 16'h1008;
		sen = 8'h03;
		tgt[5:0] = 6'h02;
		pulse();
		send(PB);
		chk_lvl(3'h2);
		pulse();
		send(PA);
		send(PC);
		chk_lvl(3'h2);
		br = sts_pkg::BR_OFF;
		pulse();
		send(PB);
		chk_lvl(3'h0);
		// Prestore keeps the newest two
		nlv = 4'h2;
		trg = 3'h0;
		prq[7:0] = 8'h60;
		stq[7:0] = 8'h44;
		pen = 8'h01;
		peq[7:0] = 8'h20;
		got.delete();
		pulse();
		send(32'h10000003);
		send(32'h20000003);
		send(32'h30000003);
		send(PE);
		chk_val(42'(got.size()), 42'h3);
		chk_val(42'(got[0][31:0]), 42'h20000003);
		chk_val(42'(got[1][31:0]), 42'h30000003);
		chk_val(42'({got[1][EW-1], got[2][EW-1]}), 42'h2);
		chk_val(got[2][32+:42], 42'h0);
		// Stalled stream fills the buffer, then drains
		pen = 8'h00;
		stq[7:0] = 8'h80;
		prq[7:0] = 8'h00;
		st_rdy = 1'b0;
		got.delete();
		pulse();
		for (int i = 0; i < 12; i++) u_sts_target_model.q.push_back(32'(i));
		cyc(60);
		chk_val(42'({st_vld, s_vld}), 42'h3);
		st_rdy = 1'b1;
		drain();
		chk_val(42'(got.size()), 42'hc);
		// Time tagging halves the depth
		cnt = sts_pkg::CNT_TIME;
		u_sts_target_model.slow = 1'b1;
		got.delete();
		pulse();
		for (int i = 0; i < 512; i++) u_sts_target_model.q.push_back(32'(i));
		drain();
		chk_val(42'(full), 42'h1);
		chk_val(42'(got.size()), 42'h200);
		chk_val(42'(got[5][32+:42] != 42'h0), 42'h1);
		// Arming sources
		u_sts_target_model.slow = 1'b0;
		cnt = sts_pkg::CNT_OFF;
		asel = sts_pkg::ARM_EXT;
		pulse();
		chk_val(42'(armed), 42'h0);
		ext = 1'b1;
		cyc(8);
		chk_val(42'(armed), 42'h1);
		ext = 1'b0;
		asel = sts_pkg::ARM_OTHER;
		pulse();
		chk_val(42'(armed), 42'h0);
		oth = 1'b1;
		cyc(3);
		chk_val(42'(armed), 42'h1);
		oth = 1'b0;
		off = 1'b1;
		pulse();
		chk_val(42'(armed), 42'h1);
		off = 1'b0;
		by = 1'b1;
		pulse();
		chk_val(42'(armed), 42'h1);
		// Storage loop with state tags, then a frozen clock enable
		mac = 1'b1;
		nlv = 4'h3;
		cnt = sts_pkg::CNT_STATES;
		cq = 8'h80;
		prq[23:0] = 24'h100804;
		stq[23:0] = 24'h804400;
		got.delete();
		pulse();
		foreach (mrow[i]) send(mrow[i]);
		chk_lvl(3'h1);
		chk_val(42'(got.size()), 42'h4);
		chk_val(got[2][32+:42], 42'h2);
		ce = 1'b0;
		pulse();
		chk_lvl(3'h1);
		stop_test();
	end
endmodule
`default_nettype wire
